/* ico_defs.svh */
// Timing constants for the interrupt gated clock output block.
// Assumes a single system clock whose rate is given here in MHz.
`ifndef ICO_DEFS_SVH
`define ICO_DEFS_SVH

`define ICO_CLK_MHZ          64'd125
`define ICO_OFF_SHORT_NS     64'd1400000
`define ICO_OFF_LONG_NS      64'd75000000
`define ICO_IRQ_DLY_MIN_NS   64'd3906250
`define ICO_IRQ_DLY_MAX_NS   64'd5859375

`define ICO_OFF_SHORT_CYC    ((`ICO_OFF_SHORT_NS * `ICO_CLK_MHZ) / 64'd1000)
`define ICO_OFF_LONG_CYC     ((`ICO_OFF_LONG_NS * `ICO_CLK_MHZ) / 64'd1000)
`define ICO_IRQ_DLY_MIN_CYC  (((`ICO_IRQ_DLY_MIN_NS * `ICO_CLK_MHZ) + 64'd999) / 64'd1000)
`define ICO_IRQ_DLY_MAX_CYC  ((`ICO_IRQ_DLY_MAX_NS * `ICO_CLK_MHZ) / 64'd1000)

`define ICO_CNT_W            24
`define ICO_SRC_N            5
`define ICO_SRC_EVENT        0
`define ICO_SRC_ALARM        1
`define ICO_SRC_COUNTDOWN    2
`define ICO_SRC_UPDATE       3
`define ICO_SRC_HIGH_TEMP    4

`endif

/* ico_pkg.sv */
// Types shared by the interrupt gated clock output block.
// Assumes ico_defs.svh is on the include path.
`include "ico_defs.svh"

package ico_pkg;
   typedef logic [`ICO_CNT_W-1:0] ico_count_type;
   typedef logic [`ICO_SRC_N-1:0] ico_src_type;
   typedef enum logic [1:0] {
      CK_OFF  = 2'b00,
      CK_ON   = 2'b01,
      CK_HOLD = 2'b10
   } ico_clk_state_type;
endpackage

/* ico_tmr_if.sv */
// Interface between the clock control logic and one delay timer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps

interface ico_tmr_if;
   import ico_pkg::*;
   logic          start;
   ico_count_type load;
   logic          busy;
   modport owner (output start, output load, input busy);
   modport timer (input start, input load, output busy);
endinterface

/* ico_timer.sv */
// Down counter that stays busy for a loaded number of cycles.
// Assumes a start pulse on the system clock; a new start reloads it.
`timescale 1ns/100ps

module ico_timer
   import ico_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  rstn_i,
   ico_tmr_if.timer   tmr
);

   ico_count_type count;
   ico_count_type next_count;

   always_comb begin
      next_count = count;
      if (tmr.start) begin
         next_count = tmr.load;
      end else if (count != '0) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign tmr.busy = (count != '0);

endmodule

/* ico_clock_gate.sv */
// Top of the interrupt gated clock output block: source select, off delay, irq delay.
// Assumes all control bits, irq signals and the bus stop pulse share MCLK_I.
//
// How it works
// R01: Select bit picks 1.4 ms or 75 ms clock-off hold after bus STOP.
// R02: The off hold and its select only act while bus-stop delay enable is one.
// R03: Irq delay enable holds selected interrupts off 1/256 s after clock turns on.
// R04: Irq delay only when clock is not directly enabled, only for selected sources.
// R05: Event select bit lets the event interrupt switch the clock output on.
// R06: Alarm select bit lets the alarm interrupt switch the clock output on.
// R07: Countdown select bit lets the countdown interrupt switch the clock on.
// R08: Update select bit lets the periodic update interrupt switch the clock on.
// R09: High temperature select bit lets that interrupt switch the clock on.
// R10: Clock request is OR of selected interrupts; reset clears every select bit.
`timescale 1ns/100ps
`include "ico_defs.svh"

module ico_clock_gate
   import ico_pkg::*;
#(
   parameter int OFF_SHORT_CYC   = int'(`ICO_OFF_SHORT_CYC),
   parameter int OFF_LONG_CYC    = int'(`ICO_OFF_LONG_CYC),
   // The hold-off uses the shortest allowed time, rounded up to whole cycles.
   parameter int IRQ_DLY_CYC     = int'(`ICO_IRQ_DLY_MIN_CYC)
)
(
   input  wire logic MCLK_I,
   input  wire logic RSTN_I,
   input  wire logic EVENT_IRQ_CLOCK_SELECT_I,
   input  wire logic ALARM_IRQ_CLOCK_SELECT_I,
   input  wire logic COUNTDOWN_IRQ_CLOCK_SELECT_I,
   input  wire logic UPDATE_IRQ_CLOCK_SELECT_I,
   input  wire logic HIGH_TEMP_IRQ_CLOCK_SELECT_I,
   input  wire logic OFF_DELAY_LONG_SELECT_I,
   input  wire logic IRQ_DELAY_ENABLE_I,
   input  wire logic BUS_STOP_CLOCK_DELAY_ENABLE_I,
   input  wire logic CLOCK_NOT_DIRECT_ENABLE_I,
   input  wire logic EVENT_IRQ_SIGNAL_I,
   input  wire logic ALARM_IRQ_SIGNAL_I,
   input  wire logic COUNTDOWN_IRQ_SIGNAL_I,
   input  wire logic UPDATE_IRQ_SIGNAL_I,
   input  wire logic HIGH_TEMP_IRQ_SIGNAL_I,
   input  wire logic BUS_STOP_I,
   output logic      CLOCK_OUTPUT_ENABLE_O,
   output logic      IRQ_O,
   output logic      CLOCK_REQUEST_O
);

   ico_src_type       select;
   ico_src_type       next_select;
   ico_src_type       irq_vec;
   logic              request;
   ico_clk_state_type state;
   ico_clk_state_type next_state;
   logic              clk_on;
   logic              clk_on_q;
   logic              next_clk_on_q;
   logic              delay_apply;
   logic              delay_wait;
   logic              irq_unsel;
   logic              irq_sel;
   logic              next_irq;
   logic              next_request;
   logic              next_clk_en;

   // Both timers count whole MCLK_I cycles, so the long hold needs the full counter width.
   ico_tmr_if off_tmr ();
   ico_tmr_if dly_tmr ();

   ico_timer u_off_timer (
      .clk_i  (MCLK_I),
      .rstn_i (RSTN_I),
      .tmr    (off_tmr)
   );

   ico_timer u_dly_timer (
      .clk_i  (MCLK_I),
      .rstn_i (RSTN_I),
      .tmr    (dly_tmr)
   );

   // Any source whose select bit is set and whose interrupt is high.
   function automatic logic sel_any(input ico_src_type irq, input ico_src_type sel);
      return |(irq & sel);
   endfunction

   // A selected interrupt or a direct enable keeps the clock running.
   function automatic logic wake_up(input logic req, input logic not_direct);
      return req | ~not_direct;
   endfunction

   // A bus STOP starts the off hold only while the hold is enabled.
   function automatic logic stop_hold(input logic stop, input logic hold_en);
      return stop & hold_en;
   endfunction

   // Select bits are held in flops so that power-on reset leaves every source off.
   always_comb begin
      next_select                     = '0;
      next_select[`ICO_SRC_EVENT]     = EVENT_IRQ_CLOCK_SELECT_I;
      next_select[`ICO_SRC_ALARM]     = ALARM_IRQ_CLOCK_SELECT_I;
      next_select[`ICO_SRC_COUNTDOWN] = COUNTDOWN_IRQ_CLOCK_SELECT_I;
      next_select[`ICO_SRC_UPDATE]    = UPDATE_IRQ_CLOCK_SELECT_I;
      next_select[`ICO_SRC_HIGH_TEMP] = HIGH_TEMP_IRQ_CLOCK_SELECT_I;
   end

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         select <= '0; // R10
      end else begin
         select <= next_select;
      end
   end

   always_comb begin
      irq_vec                     = '0;
      irq_vec[`ICO_SRC_EVENT]     = EVENT_IRQ_SIGNAL_I;
      irq_vec[`ICO_SRC_ALARM]     = ALARM_IRQ_SIGNAL_I;
      irq_vec[`ICO_SRC_COUNTDOWN] = COUNTDOWN_IRQ_SIGNAL_I;
      irq_vec[`ICO_SRC_UPDATE]    = UPDATE_IRQ_SIGNAL_I;
      irq_vec[`ICO_SRC_HIGH_TEMP] = HIGH_TEMP_IRQ_SIGNAL_I;
   end

   always_comb begin
      request = 1'b0;
      request = request | (select[`ICO_SRC_EVENT] & irq_vec[`ICO_SRC_EVENT]); // R05
      request = request | (select[`ICO_SRC_ALARM] & irq_vec[`ICO_SRC_ALARM]); // R06
      request = request | (select[`ICO_SRC_COUNTDOWN] & irq_vec[`ICO_SRC_COUNTDOWN]); // R07
      request = request | (select[`ICO_SRC_UPDATE] & irq_vec[`ICO_SRC_UPDATE]); // R08
      request = request | (select[`ICO_SRC_HIGH_TEMP] & irq_vec[`ICO_SRC_HIGH_TEMP]); // R09
   end

   // Clock output state. A direct enable keeps the clock running regardless of sources.
   always_comb begin
      next_state    = state;
      off_tmr.start = 1'b0;
      off_tmr.load  = ico_count_type'(OFF_SHORT_CYC);
      if (OFF_DELAY_LONG_SELECT_I) begin
         off_tmr.load = ico_count_type'(OFF_LONG_CYC); // R01
      end
      case (state)
         CK_OFF: begin
            if (wake_up(request, CLOCK_NOT_DIRECT_ENABLE_I)) begin
               next_state = CK_ON; // R10
            end else if (stop_hold(BUS_STOP_I, BUS_STOP_CLOCK_DELAY_ENABLE_I)) begin
               next_state    = CK_HOLD; // R02
               off_tmr.start = 1'b1; // R01
            end
         end
         CK_ON: begin
            if (wake_up(request, CLOCK_NOT_DIRECT_ENABLE_I)) begin
               next_state = CK_ON;
            end else if (stop_hold(BUS_STOP_I, BUS_STOP_CLOCK_DELAY_ENABLE_I)) begin
               next_state    = CK_HOLD; // R02
               off_tmr.start = 1'b1; // R01
            end else begin
               next_state = CK_OFF;
            end
         end
         CK_HOLD: begin
            if (wake_up(request, CLOCK_NOT_DIRECT_ENABLE_I)) begin
               next_state = CK_ON;
            end else if (stop_hold(BUS_STOP_I, BUS_STOP_CLOCK_DELAY_ENABLE_I)) begin
               // A STOP during the hold restarts it, so bus traffic keeps the clock alive.
               off_tmr.start = 1'b1; // R01
            end else if (!off_tmr.busy || !BUS_STOP_CLOCK_DELAY_ENABLE_I) begin
               next_state = CK_OFF; // R02
            end
         end
         default: begin
            next_state = CK_OFF;
         end
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         state <= CK_OFF;
      end else begin
         state <= next_state;
      end
   end

   // The delay starts on the cycle the clock output turns on, so the first
   // selected interrupt after a wake is held back by the full minimum time.
   assign clk_on        = (next_state != CK_OFF);
   assign next_clk_on_q = clk_on;
   assign delay_apply   = IRQ_DELAY_ENABLE_I & CLOCK_NOT_DIRECT_ENABLE_I; // R04

   always_comb begin
      dly_tmr.start = clk_on & ~clk_on_q & delay_apply; // R03
      dly_tmr.load  = ico_count_type'(IRQ_DLY_CYC); // R03
   end

   assign delay_wait = delay_apply & (dly_tmr.busy | dly_tmr.start | ~clk_on); // R03

   // Unselected interrupts never wake the clock, so holding them back would gain nothing.
   always_comb begin
      irq_unsel = sel_any(irq_vec, ~select);
      irq_sel   = sel_any(irq_vec, select);
      next_irq  = irq_unsel | (irq_sel & ~delay_wait); // R04
   end

   assign next_request = request;
   assign next_clk_en  = clk_on;
   // The edge memory resets low like the enable output, so no false hold-off follows reset.

   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         clk_on_q              <= 1'b0;
         CLOCK_OUTPUT_ENABLE_O <= 1'b0;
         IRQ_O                 <= 1'b0;
         CLOCK_REQUEST_O       <= 1'b0;
      end else begin
         clk_on_q              <= next_clk_on_q;
         CLOCK_OUTPUT_ENABLE_O <= next_clk_en;
         IRQ_O                 <= next_irq;
         CLOCK_REQUEST_O       <= next_request;
      end
   end

endmodule

/* ico_clk_sink.sv */
// Far side model: system logic that counts the cycles the clock output runs.
// Assumes it shares the block's clock and reset.
`timescale 1ns/100ps

module ico_clk_sink (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic clk_en_i,
   output int        on_cnt_o
);
   always_ff @(posedge clk_i) begin
      if (!rstn_i)
         on_cnt_o <= 0;
      else if (clk_en_i)
         on_cnt_o <= on_cnt_o + 1;
   end
endmodule

/* ico_clock_gate_chk.sv */
// Port checks of the gated clock output block.
// Assumes a bind with the block's own count parameters.
`timescale 1ns/100ps

module ico_clock_gate_chk #(
   parameter int OFF_SHORT_CYC = 20,
   parameter int OFF_LONG_CYC  = 50,
   parameter int IRQ_DLY_CYC   = 10
)(
   input wire logic MCLK_I,
   input wire logic RSTN_I,
   input wire logic EVENT_IRQ_CLOCK_SELECT_I,
   input wire logic ALARM_IRQ_CLOCK_SELECT_I,
   input wire logic COUNTDOWN_IRQ_CLOCK_SELECT_I,
   input wire logic UPDATE_IRQ_CLOCK_SELECT_I,
   input wire logic HIGH_TEMP_IRQ_CLOCK_SELECT_I,
   input wire logic OFF_DELAY_LONG_SELECT_I,
   input wire logic IRQ_DELAY_ENABLE_I,
   input wire logic BUS_STOP_CLOCK_DELAY_ENABLE_I,
   input wire logic CLOCK_NOT_DIRECT_ENABLE_I,
   input wire logic EVENT_IRQ_SIGNAL_I,
   input wire logic ALARM_IRQ_SIGNAL_I,
   input wire logic COUNTDOWN_IRQ_SIGNAL_I,
   input wire logic UPDATE_IRQ_SIGNAL_I,
   input wire logic HIGH_TEMP_IRQ_SIGNAL_I,
   input wire logic BUS_STOP_I,
   input wire logic CLOCK_OUTPUT_ENABLE_O,
   input wire logic IRQ_O,
   input wire logic CLOCK_REQUEST_O
);
   localparam int S_GAP = OFF_SHORT_CYC - 9;
   localparam int L_GAP = OFF_LONG_CYC - 9;
   localparam int D_LO  = IRQ_DLY_CYC - 9;
   localparam int D_HI  = IRQ_DLY_CYC - 4;
   wire logic [4:0] sel_v = {HIGH_TEMP_IRQ_CLOCK_SELECT_I, UPDATE_IRQ_CLOCK_SELECT_I,
      COUNTDOWN_IRQ_CLOCK_SELECT_I, ALARM_IRQ_CLOCK_SELECT_I, EVENT_IRQ_CLOCK_SELECT_I};
   wire logic [4:0] irq_v = {HIGH_TEMP_IRQ_SIGNAL_I, UPDATE_IRQ_SIGNAL_I,
      COUNTDOWN_IRQ_SIGNAL_I, ALARM_IRQ_SIGNAL_I, EVENT_IRQ_SIGNAL_I};
   wire logic stop_idle = BUS_STOP_I && BUS_STOP_CLOCK_DELAY_ENABLE_I &&
      CLOCK_NOT_DIRECT_ENABLE_I && !CLOCK_REQUEST_O && (irq_v == 5'h00);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RSTN_I);
   // The select flop lags its input and is cleared in reset, hence the depth of two.
   chk_req_or: assert property (CLOCK_REQUEST_O ==
      ($past(RSTN_I, 2) && |($past(sel_v, 2) & $past(irq_v))))
      else $error("clock request mismatch");
   chk_req_clock: assert property (CLOCK_REQUEST_O |-> CLOCK_OUTPUT_ENABLE_O)
      else $error("request without clock");
   chk_direct_on: assert property (!CLOCK_NOT_DIRECT_ENABLE_I |=> CLOCK_OUTPUT_ENABLE_O)
      else $error("direct clock not on");
   chk_clock_off: assert property (CLOCK_OUTPUT_ENABLE_O && !CLOCK_REQUEST_O &&
      !$past(BUS_STOP_CLOCK_DELAY_ENABLE_I) |-> !$past(CLOCK_NOT_DIRECT_ENABLE_I))
      else $error("clock on without cause");
   chk_hold_short: assert property (stop_idle && !OFF_DELAY_LONG_SELECT_I |-> ##1
      CLOCK_OUTPUT_ENABLE_O[*8] ##S_GAP CLOCK_OUTPUT_ENABLE_O ##[1:3] !CLOCK_OUTPUT_ENABLE_O)
      else $error("short hold wrong");
   chk_hold_long: assert property (stop_idle && OFF_DELAY_LONG_SELECT_I |-> ##1
      CLOCK_OUTPUT_ENABLE_O[*8] ##L_GAP CLOCK_OUTPUT_ENABLE_O ##[1:3] !CLOCK_OUTPUT_ENABLE_O)
      else $error("long hold wrong");
   chk_irq_delay: assert property ($rose(CLOCK_OUTPUT_ENABLE_O) && CLOCK_REQUEST_O &&
      $past(IRQ_DELAY_ENABLE_I) && $past(CLOCK_NOT_DIRECT_ENABLE_I) &&
      (($past(irq_v) & ~$past(sel_v)) == 5'h00) |-> !IRQ_O[*8] ##[D_LO:D_HI] IRQ_O)
      else $error("irq delay wrong");
   chk_irq_pass: assert property (!IRQ_DELAY_ENABLE_I |=> IRQ_O == |$past(irq_v))
      else $error("irq not passed");
   chk_reset_clear: assert property (disable iff (1'b0) !RSTN_I |=>
      !CLOCK_REQUEST_O && !CLOCK_OUTPUT_ENABLE_O && !IRQ_O)
      else $error("outputs not cleared");
endmodule

/* ico_clock_gate_tb_top.sv */
// Self-checking bench of the gated clock output block.
// Assumes the checker and the clock sink model are compiled first.
`timescale 1ns/100ps

module ico_clock_gate_tb_top;
   localparam int SHORT = 20;
   localparam int LONG  = 50;
   localparam int DLY   = 10;
   logic       MCLK_I = 1'b0;
   logic       RSTN_I = 1'b0;
   logic [4:0] sel = 5'h00;
   logic [4:0] irq = 5'h00;
   logic       OFF_DELAY_LONG_SELECT_I = 1'b0;
   logic       IRQ_DELAY_ENABLE_I = 1'b0;
   logic       BUS_STOP_CLOCK_DELAY_ENABLE_I = 1'b0;
   logic       CLOCK_NOT_DIRECT_ENABLE_I = 1'b1;
   logic       BUS_STOP_I = 1'b0;
   logic       CLOCK_OUTPUT_ENABLE_O;
   logic       IRQ_O;
   logic       CLOCK_REQUEST_O;
   wire logic  EVENT_IRQ_CLOCK_SELECT_I = sel[0];
   wire logic  ALARM_IRQ_CLOCK_SELECT_I = sel[1];
   wire logic  COUNTDOWN_IRQ_CLOCK_SELECT_I = sel[2];
   wire logic  UPDATE_IRQ_CLOCK_SELECT_I = sel[3];
   wire logic  HIGH_TEMP_IRQ_CLOCK_SELECT_I = sel[4];
   wire logic  EVENT_IRQ_SIGNAL_I = irq[0];
   wire logic  ALARM_IRQ_SIGNAL_I = irq[1];
   wire logic  COUNTDOWN_IRQ_SIGNAL_I = irq[2];
   wire logic  UPDATE_IRQ_SIGNAL_I = irq[3];
   wire logic  HIGH_TEMP_IRQ_SIGNAL_I = irq[4];
   int         on_cnt;
   int         err_total = 0;
   int         comparisons = 0;
   int         cyc = 0;

   always #4 MCLK_I = ~MCLK_I;

   ico_clock_gate #(.OFF_SHORT_CYC(SHORT), .OFF_LONG_CYC(LONG), .IRQ_DLY_CYC(DLY)) dut (.*);
   ico_clk_sink sink (.clk_i(MCLK_I), .rstn_i(RSTN_I), .clk_en_i(CLOCK_OUTPUT_ENABLE_O),
      .on_cnt_o(on_cnt));

   task automatic tick(input int n);
      repeat (n) @(posedge MCLK_I);
      #1;
   endtask

   task automatic chk(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
      end
   endtask

   // Selects held high through reset must not reach the request until the flop loads.
   task automatic t_reset();
      sel = 5'h01;
      irq = 5'h01;
      tick(3);
      RSTN_I = 1'b1;
      chk(CLOCK_OUTPUT_ENABLE_O | IRQ_O | CLOCK_REQUEST_O, 1'b0);
      tick(1);
      chk(CLOCK_REQUEST_O, 1'b0);
      tick(1);
      chk(CLOCK_REQUEST_O, 1'b1);
      sel = 5'h00;
      irq = 5'h00;
      tick(3);
      $display("reset test done");
   endtask

   // An unselected source must leave the clock off; a selected one switches it on.
   task automatic t_src(input int i);
      irq[i] = 1'b1;
      tick(3);
      chk(CLOCK_OUTPUT_ENABLE_O, 1'b0);
      sel[i] = 1'b1;
      tick(3);
      chk(CLOCK_REQUEST_O, 1'b1);
      chk(CLOCK_OUTPUT_ENABLE_O, 1'b1);
      irq[i] = 1'b0;
      tick(2);
      chk(CLOCK_OUTPUT_ENABLE_O, 1'b0);
      sel[i] = 1'b0;
      $display("source test %0d done", i);
   endtask

   task automatic t_hold(input logic lng, input logic en, input int lo, input int hi);
      int c0;
      OFF_DELAY_LONG_SELECT_I = lng;
      BUS_STOP_CLOCK_DELAY_ENABLE_I = en;
      tick(2);
      c0 = on_cnt;
      BUS_STOP_I = 1'b1;
      tick(1);
      BUS_STOP_I = 1'b0;
      tick(60);
      chk_rng(on_cnt - c0, lo, hi);
      BUS_STOP_CLOCK_DELAY_ENABLE_I = 1'b0;
      $display("hold test done");
   endtask

   // Edges from the interrupt rising to the interrupt output rising.
   task automatic t_irqd(input int i, input logic s, input logic dir, input int lo, input int hi);
      int n;
      IRQ_DELAY_ENABLE_I = 1'b1;
      CLOCK_NOT_DIRECT_ENABLE_I = !dir;
      sel[i] = s;
      tick(3);
      n = 0;
      irq[i] = 1'b1;
      tick(1);
      while (IRQ_O !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      chk_rng(n + 1, lo, hi);
      irq[i] = 1'b0;
      sel[i] = 1'b0;
      IRQ_DELAY_ENABLE_I = 1'b0;
      CLOCK_NOT_DIRECT_ENABLE_I = 1'b1;
      tick(4);
      $display("irq delay test done");
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge MCLK_I) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         stop_test();
      end
   end

   initial begin
      t_reset();
      for (int i = 0; i < 5; i++)
         t_src(i);
      t_hold(1'b0, 1'b1, SHORT - 1, SHORT + 2);
      t_hold(1'b1, 1'b1, LONG - 1, LONG + 2);
      t_hold(1'b0, 1'b0, 0, 0);
      t_hold(1'b1, 1'b0, 0, 0);
      t_irqd(0, 1'b1, 1'b0, DLY + 1, DLY + 4);
      t_irqd(0, 1'b1, 1'b1, 1, 1);
      t_irqd(1, 1'b0, 1'b0, 1, 1);
      stop_test();
   end
endmodule

bind ico_clock_gate ico_clock_gate_chk #(.OFF_SHORT_CYC(OFF_SHORT_CYC),
   .OFF_LONG_CYC(OFF_LONG_CYC), .IRQ_DLY_CYC(IRQ_DLY_CYC)) chk (.*);
